// file: rtl/bridge_init_pkg.sv
// Package: constants and types for the power-up and init sequencer
package bridge_init_pkg;
    // Clock and timing
    localparam int unsigned MCLK_HZ           = 25_000_000;
    localparam int unsigned I2C_READY_MS      = 2;
    localparam int unsigned HARD_RESET_MS     = 2;
    localparam int unsigned I2C_READY_CYCLES  = (MCLK_HZ / 1000) * I2C_READY_MS;
    localparam int unsigned HARD_RESET_CYCLES = (MCLK_HZ / 1000) * HARD_RESET_MS;
    localparam int unsigned CNT_W             = 24;

    // Register offsets
    localparam logic [7:0] ADDR_EVENT_FILTER  = 8'h16;
    localparam logic [7:0] ADDR_PAGE_SELECT   = 8'h40;
    localparam logic [7:0] ADDR_REG_INDEX     = 8'h41;
    localparam logic [7:0] ADDR_REG_DATA      = 8'h42;
    localparam logic [7:0] ADDR_PLL_AUTO_RST  = 8'h5B;

    // Paged locations and bit positions
    localparam logic [7:0] PAGE_VIDEO_PLL     = 8'h10;
    localparam logic [7:0] PAGE_LINK_PLL      = 8'h14;
    localparam logic [7:0] IDX_PLL_SM_CNTL    = 8'h49;
    localparam int unsigned PLL_RESET_BIT     = 4;
    localparam int unsigned AUTO_RST_BIT      = 5;

    // Reset values
    localparam logic [7:0] RST_EVENT_FILTER   = 8'h00;
    localparam logic [7:0] RST_PLL_AUTO_RST   = 8'h20;
    localparam logic [7:0] RST_ZERO           = 8'h00;

    // Register write strobe from the link domain
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

    // Readback request
    typedef struct packed {
        logic [7:0] addr;
    } reg_read_t;

    typedef enum logic [1:0] {
        PWR_OFF   = 2'b00,
        PWR_WAIT  = 2'b01,
        PWR_READY = 2'b11
    } power_state_t;
endpackage

// file: rtl/link_write_sync.sv
// Module: carries register writes from the link clock into the core clock
`timescale 1ns/1ps
module link_write_sync (
    // Link side
    input  wire logic                        link_clk_i,
    input  wire logic                        link_wr_i,
    input  wire bridge_init_pkg::reg_write_t link_wr_data_i,
    // Core side
    input  wire logic                        mclk_i,
    input  wire logic                        reset_n_i,
    output logic                             wr_pulse_o,
    output bridge_init_pkg::reg_write_t      wr_data_o
);
    logic                        toggle;
    bridge_init_pkg::reg_write_t hold;
    logic                        sync1;
    logic                        sync2;
    logic                        sync3;

    // Capture word and flip toggle on the link clock
    always_ff @(posedge link_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            toggle <= 1'b0;
            hold   <= '0;
        end else if (link_wr_i) begin
            toggle <= ~toggle;
            hold   <= link_wr_data_i;
        end
    end

    // Two-stage synchroniser then edge detect
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= toggle;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Held word is stable once the toggle edge is seen
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_pulse_o <= 1'b0;
            wr_data_o  <= '0;
        end else begin
            wr_pulse_o <= sync2 ^ sync3;
            if (sync2 ^ sync3) begin
                wr_data_o <= hold;
            end
        end
    end
endmodule

// file: rtl/bridge_powerup_init_sequencer.sv
// Module: chip-enable power-up timing and init register block
// Function
// - Chip enable is active high
// - Register access ready 2 ms after enable
// - Enable low 2 ms forces hard reset
// - Clearing pll_auto_reset_control bit 5 stops auto reset
// - Writing 0x02 to i2c_event_filter_setting shortens events
// - Reset video PLL through page 0x10
// - Then reset link PLL through page 0x14
// - Pages reached by select, index, data registers
// - Paged 0x49 bit 4 holds PLL reset
`timescale 1ns/1ps
module bridge_powerup_init_sequencer (
    // Core clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    // Chip enable pin
    input  wire logic        chip_enable_pin_i,
    // Register access from the link domain
    input  wire logic        link_clk_i,
    input  wire logic        link_wr_i,
    input  wire logic [7:0]  link_wr_addr_i,
    input  wire logic [7:0]  link_wr_data_i,
    // Readback in core domain
    input  wire logic [7:0]  rd_addr_i,
    output logic      [7:0]  rd_data_o,
    // Status
    output logic             device_active_o,
    output logic             reg_access_ready_o,
    output logic             write_dropped_o,
    // PLL controls and event filter
    output logic             video_pll_reset_o,
    output logic             link_pll_reset_o,
    output logic             link_pll_auto_reset_en_o,
    output logic      [7:0]  event_filter_o
);
    logic                            en_s1;
    logic                            en_s2;
    bridge_init_pkg::power_state_t   state;
    logic [bridge_init_pkg::CNT_W-1:0] high_cnt;
    logic [bridge_init_pkg::CNT_W-1:0] low_cnt;
    logic                            hard_reset;
    logic                            wr_pulse;
    bridge_init_pkg::reg_write_t     wr_link;
    bridge_init_pkg::reg_write_t     wr;
    logic [7:0]                      event_filter;
    logic [7:0]                      auto_rst;
    logic [7:0]                      page_sel;
    logic [7:0]                      reg_idx;
    logic [7:0]                      reg_data;
    logic                            video_rst;
    logic                            link_rst;
    logic                            wr_ok;

    // Decode a register write to a given address
    function automatic logic hit(input bridge_init_pkg::reg_write_t w, input logic [7:0] a);
        return w.addr == a;
    endfunction

    assign wr_link.addr = link_wr_addr_i;
    assign wr_link.data = link_wr_data_i;

    // Writes cross from the link clock
    link_write_sync u_sync (
        .link_clk_i     (link_clk_i),
        .link_wr_i      (link_wr_i),
        .link_wr_data_i (wr_link),
        .mclk_i         (mclk_i),
        .reset_n_i      (reset_n_i),
        .wr_pulse_o     (wr_pulse),
        .wr_data_o      (wr)
    );

    // Enable pin synchroniser
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
        end else begin
            en_s1 <= chip_enable_pin_i;
            en_s2 <= en_s1;
        end
    end

    // Low-time counter; long low pulse triggers hard reset
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_cnt    <= '0;
            hard_reset <= 1'b1;
        end else if (en_s2) begin
            low_cnt    <= '0;
            hard_reset <= 1'b0;
        end else if (low_cnt >= bridge_init_pkg::CNT_W'(bridge_init_pkg::HARD_RESET_CYCLES - 1)) begin
            hard_reset <= 1'b1;
        end else begin
            low_cnt <= low_cnt + 1'b1;
        end
    end

    // Power state: off, waiting for access, ready
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state    <= bridge_init_pkg::PWR_OFF;
            high_cnt <= '0;
        end else if (hard_reset) begin
            state    <= bridge_init_pkg::PWR_OFF;
            high_cnt <= '0;
        end else begin
            unique case (state)
                bridge_init_pkg::PWR_OFF: begin
                    if (en_s2) begin
                        state <= bridge_init_pkg::PWR_WAIT;
                    end
                end
                bridge_init_pkg::PWR_WAIT: begin
                    if (high_cnt >= bridge_init_pkg::CNT_W'(bridge_init_pkg::I2C_READY_CYCLES - 1)) begin
                        state <= bridge_init_pkg::PWR_READY;
                    end else begin
                        high_cnt <= high_cnt + 1'b1;
                    end
                end
                bridge_init_pkg::PWR_READY: begin
                    state <= bridge_init_pkg::PWR_READY;
                end
                default: begin
                    state <= bridge_init_pkg::PWR_OFF;
                end
            endcase
        end
    end

    assign wr_ok = wr_pulse && (state == bridge_init_pkg::PWR_READY);

    // Direct registers
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_filter <= bridge_init_pkg::RST_EVENT_FILTER;
            auto_rst     <= bridge_init_pkg::RST_PLL_AUTO_RST;
        end else if (hard_reset) begin
            event_filter <= bridge_init_pkg::RST_EVENT_FILTER;
            auto_rst     <= bridge_init_pkg::RST_PLL_AUTO_RST;
        end else if (wr_ok) begin
            if (hit(wr, bridge_init_pkg::ADDR_EVENT_FILTER)) begin
                event_filter <= wr.data;
            end
            if (hit(wr, bridge_init_pkg::ADDR_PLL_AUTO_RST)) begin
                auto_rst <= wr.data;
            end
        end
    end

    // Indirect page access registers
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            page_sel <= bridge_init_pkg::RST_ZERO;
            reg_idx  <= bridge_init_pkg::RST_ZERO;
            reg_data <= bridge_init_pkg::RST_ZERO;
        end else if (hard_reset) begin
            page_sel <= bridge_init_pkg::RST_ZERO;
            reg_idx  <= bridge_init_pkg::RST_ZERO;
            reg_data <= bridge_init_pkg::RST_ZERO;
        end else if (wr_ok) begin
            if (hit(wr, bridge_init_pkg::ADDR_PAGE_SELECT)) begin
                page_sel <= wr.data;
            end
            if (hit(wr, bridge_init_pkg::ADDR_REG_INDEX)) begin
                reg_idx <= wr.data;
            end
            if (hit(wr, bridge_init_pkg::ADDR_REG_DATA)) begin
                reg_data <= wr.data;
            end
        end
    end

    // Paged PLL state-machine reset bits
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            video_rst <= 1'b0;
            link_rst  <= 1'b0;
        end else if (hard_reset) begin
            video_rst <= 1'b0;
            link_rst  <= 1'b0;
        end else if (wr_ok && hit(wr, bridge_init_pkg::ADDR_REG_DATA)
                     && reg_idx == bridge_init_pkg::IDX_PLL_SM_CNTL) begin
            if (page_sel == bridge_init_pkg::PAGE_VIDEO_PLL) begin
                video_rst <= wr.data[bridge_init_pkg::PLL_RESET_BIT];
            end
            if (page_sel == bridge_init_pkg::PAGE_LINK_PLL) begin
                link_rst <= wr.data[bridge_init_pkg::PLL_RESET_BIT];
            end
        end
    end

    // Readback mux
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= 8'h00;
        end else begin
            unique case (rd_addr_i)
                bridge_init_pkg::ADDR_EVENT_FILTER: rd_data_o <= event_filter;
                bridge_init_pkg::ADDR_PLL_AUTO_RST: rd_data_o <= auto_rst;
                bridge_init_pkg::ADDR_PAGE_SELECT:  rd_data_o <= page_sel;
                bridge_init_pkg::ADDR_REG_INDEX:    rd_data_o <= reg_idx;
                bridge_init_pkg::ADDR_REG_DATA:     rd_data_o <= reg_data;
                default:                            rd_data_o <= 8'h00;
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            device_active_o          <= 1'b0;
            reg_access_ready_o       <= 1'b0;
            write_dropped_o          <= 1'b0;
            video_pll_reset_o        <= 1'b0;
            link_pll_reset_o         <= 1'b0;
            link_pll_auto_reset_en_o <= 1'b1;
            event_filter_o           <= 8'h00;
        end else begin
            device_active_o          <= state != bridge_init_pkg::PWR_OFF;
            reg_access_ready_o       <= state == bridge_init_pkg::PWR_READY;
            write_dropped_o          <= wr_pulse && (state != bridge_init_pkg::PWR_READY);
            video_pll_reset_o        <= video_rst;
            link_pll_reset_o         <= link_rst;
            link_pll_auto_reset_en_o <= auto_rst[bridge_init_pkg::AUTO_RST_BIT];
            event_filter_o           <= event_filter;
        end
    end
endmodule

// file: sim/host_link_model.sv
// Host model: spaced link-side register writes
`timescale 1ns/1ps
module host_link_model (
    // Link clock
    input  wire logic  link_clk_i,
    // Write strobe and payload
    output logic       link_wr_o,
    output logic [7:0] link_wr_addr_o,
    output logic [7:0] link_wr_data_o
);
    // Quiet until asked
    initial begin
        link_wr_o = 1'b0;
        link_wr_addr_o = 8'h00;
        link_wr_data_o = 8'h00;
    end
    // Gap, one-cycle strobe, then payload scrambled
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        repeat (4) @(negedge link_clk_i);
        link_wr_o = 1'b1;
        link_wr_addr_o = a;
        link_wr_data_o = d;
        @(negedge link_clk_i);
        link_wr_o = 1'b0;
        link_wr_addr_o = ~a;
        link_wr_data_o = ~d;
    endtask
endmodule

// file: sim/bridge_seq_props_props.sv
// Checker: enable timing and register effects at the ports
`timescale 1ns/1ps
module bridge_seq_props (
    // Clock, reset, enable, readback
    input wire logic       mclk_i,
    input wire logic       reset_n_i,
    input wire logic       chip_enable_pin_i,
    input wire logic [7:0] rd_addr_i,
    input wire logic [7:0] rd_data_o,
    // Status and controls
    input wire logic       device_active_o,
    input wire logic       reg_access_ready_o,
    input wire logic       write_dropped_o,
    input wire logic       video_pll_reset_o,
    input wire logic       link_pll_reset_o,
    input wire logic       link_pll_auto_reset_en_o,
    input wire logic [7:0] event_filter_o
);
    logic [23:0] hi_cnt;
    logic [23:0] lo_cnt;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // Runs of enable high and low
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hi_cnt <= 24'h0;
            lo_cnt <= 24'h0;
        end else begin
            hi_cnt <= chip_enable_pin_i ? hi_cnt + {23'h0, hi_cnt != 24'hFFFFFF} : 24'h0;
            lo_cnt <= chip_enable_pin_i ? 24'h0 : lo_cnt + {23'h0, lo_cnt != 24'hFFFFFF};
        end
    end
    chk_ready_not_early: assert property ($rose(reg_access_ready_o) |->
        hi_cnt >= bridge_init_pkg::I2C_READY_CYCLES) else $error("ready too early");
    chk_ready_on_time: assert property (hi_cnt == bridge_init_pkg::I2C_READY_CYCLES + 16
        |-> reg_access_ready_o) else $error("ready too late");
    chk_ready_needs_active: assert property (reg_access_ready_o |-> device_active_o)
        else $error("ready while inactive");
    chk_active_after_enable: assert property ($rose(device_active_o) |-> hi_cnt >= 2)
        else $error("active without enable");
    chk_reset_not_short: assert property ($fell(device_active_o) |->
        lo_cnt >= bridge_init_pkg::HARD_RESET_CYCLES) else $error("hard reset too soon");
    chk_hard_reset_done: assert property (lo_cnt == bridge_init_pkg::HARD_RESET_CYCLES + 8 |->
        !device_active_o && !reg_access_ready_o && !video_pll_reset_o && !link_pll_reset_o
        && link_pll_auto_reset_en_o && event_filter_o == 8'h00) else $error("hard reset missed");
    chk_frozen_unready: assert property ((!reg_access_ready_o)[*4] |-> $stable(event_filter_o)
        && $stable(link_pll_auto_reset_en_o) && $stable({video_pll_reset_o, link_pll_reset_o}))
        else $error("register moved while not ready");
    chk_drop_unready: assert property (write_dropped_o |-> !reg_access_ready_o)
        else $error("drop while ready");
    chk_filter_readback: assert property ($past(rd_addr_i) == 8'h16 |->
        rd_data_o == event_filter_o) else $error("filter readback");
    chk_auto_readback: assert property ($past(rd_addr_i) == 8'h5B |->
        rd_data_o[5] == link_pll_auto_reset_en_o) else $error("auto reset readback");
    chk_pll_needs_ready: assert property ($rose(video_pll_reset_o) || $rose(link_pll_reset_o)
        |-> reg_access_ready_o) else $error("pll reset while not ready");
    cover property ($rose(reg_access_ready_o));
    cover property ($rose(video_pll_reset_o));
    cover property ($fell(link_pll_auto_reset_en_o));
    cover property (write_dropped_o);
endmodule
bind bridge_powerup_init_sequencer bridge_seq_props u_props (
    .mclk_i                   (mclk_i),
    .reset_n_i                (reset_n_i),
    .chip_enable_pin_i        (chip_enable_pin_i),
    .rd_addr_i                (rd_addr_i),
    .rd_data_o                (rd_data_o),
    .device_active_o          (device_active_o),
    .reg_access_ready_o       (reg_access_ready_o),
    .write_dropped_o          (write_dropped_o),
    .video_pll_reset_o        (video_pll_reset_o),
    .link_pll_reset_o         (link_pll_reset_o),
    .link_pll_auto_reset_en_o (link_pll_auto_reset_en_o),
    .event_filter_o           (event_filter_o)
);

// file: sim/test_bridge_powerup_init_sequencer.sv
// Testbench: enable timing, init sequences and hard reset
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; $display("BAD %0t got %0h exp %0h", $time, (a), (e)); end end
module test_bridge_powerup_init_sequencer;
    logic       mclk_i = 1'b0;
    logic       link_clk = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       chip_enable_pin_i = 1'b0;
    logic [7:0] rd_addr_i = 8'h00;
    logic       lwr;
    logic [7:0] laddr;
    logic [7:0] ldata;
    logic [7:0] rd_data_o;
    logic [7:0] event_filter_o;
    logic       device_active_o;
    logic       reg_access_ready_o;
    logic       write_dropped_o;
    logic       video_pll_reset_o;
    logic       link_pll_reset_o;
    logic       link_pll_auto_reset_en_o;
    int         error_cnt = 0;
    int         cmp_count = 0;
    time        en_t;
    // Core and link clocks, unrelated phase
    initial forever #20 mclk_i = ~mclk_i;
    initial begin
        #7;
        forever #80 link_clk = ~link_clk;
    end
    host_link_model u_host (.link_clk_i(link_clk), .link_wr_o(lwr), .link_wr_addr_o(laddr),
        .link_wr_data_o(ldata));
    bridge_powerup_init_sequencer u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .chip_enable_pin_i(chip_enable_pin_i), .link_clk_i(link_clk), .link_wr_i(lwr),
        .link_wr_addr_i(laddr), .link_wr_data_i(ldata), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
        .device_active_o(device_active_o), .reg_access_ready_o(reg_access_ready_o),
        .write_dropped_o(write_dropped_o), .video_pll_reset_o(video_pll_reset_o),
        .link_pll_reset_o(link_pll_reset_o), .link_pll_auto_reset_en_o(link_pll_auto_reset_en_o),
        .event_filter_o(event_filter_o));
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_addr_i = a;
        cyc(2);
        `CHK(rd_data_o, e)
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.write(a, d);
        cyc(12);
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Values straight out of reset, enable still low
    task automatic t_reset;
        `CHK({device_active_o, reg_access_ready_o, video_pll_reset_o, link_pll_reset_o}, 4'h0)
        rd(bridge_init_pkg::ADDR_PLL_AUTO_RST, 8'h20);
    endtask
    // Write right after enable is refused
    task automatic t_early;
        int n;
        chip_enable_pin_i = 1'b1;
        en_t = $time;
        u_host.write(bridge_init_pkg::ADDR_EVENT_FILTER, 8'h02);
        n = 0;
        while (write_dropped_o !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        `CHK(write_dropped_o, 1'b1)
        cyc(4);
        `CHK(event_filter_o, 8'h00)
    endtask
    // Ready comes no sooner than 2 ms
    task automatic t_ready;
        int n;
        n = 0;
        while (reg_access_ready_o !== 1'b1 && n < 50100) begin
            cyc(1);
            n++;
        end
        `CHK(reg_access_ready_o, 1'b1)
        `CHK(($time - en_t) >= 64'd2000000, 1'b1)
    endtask
    // Sequence A
    task automatic t_seq_a;
        wr(bridge_init_pkg::ADDR_PLL_AUTO_RST, 8'h00);
        wr(bridge_init_pkg::ADDR_EVENT_FILTER, 8'h02);
        `CHK(link_pll_auto_reset_en_o, 1'b0)
        `CHK(event_filter_o, 8'h02)
        rd(bridge_init_pkg::ADDR_EVENT_FILTER, 8'h02);
    endtask
    // Sequence B, with a wrong index first on each page
    task automatic t_seq_b;
        logic [7:0] pg [2];
        pg = '{bridge_init_pkg::PAGE_VIDEO_PLL, bridge_init_pkg::PAGE_LINK_PLL};
        cyc(30);
        for (int i = 0; i < 2; i++) begin
            wr(bridge_init_pkg::ADDR_PAGE_SELECT, pg[i]);
            wr(bridge_init_pkg::ADDR_REG_INDEX, 8'h48);
            wr(bridge_init_pkg::ADDR_REG_DATA, 8'h10);
            `CHK({video_pll_reset_o, link_pll_reset_o}, 2'b00)
            wr(bridge_init_pkg::ADDR_REG_INDEX, bridge_init_pkg::IDX_PLL_SM_CNTL);
            wr(bridge_init_pkg::ADDR_REG_DATA, 8'h10);
            `CHK({video_pll_reset_o, link_pll_reset_o}, (i == 0) ? 2'b10 : 2'b01)
            wr(bridge_init_pkg::ADDR_REG_DATA, 8'h00);
            `CHK({video_pll_reset_o, link_pll_reset_o}, 2'b00)
        end
        rd(bridge_init_pkg::ADDR_PAGE_SELECT, 8'h14);
        rd(bridge_init_pkg::ADDR_REG_INDEX, bridge_init_pkg::IDX_PLL_SM_CNTL);
        rd(bridge_init_pkg::ADDR_REG_DATA, 8'h00);
        rd(8'h77, 8'h00);
    endtask
    // Short low pulse ignored, long one resets
    task automatic t_hard;
        chip_enable_pin_i = 1'b0;
        cyc(20);
        chip_enable_pin_i = 1'b1;
        cyc(10);
        `CHK({device_active_o, reg_access_ready_o}, 2'b11)
        chip_enable_pin_i = 1'b0;
        cyc(50030);
        `CHK({device_active_o, reg_access_ready_o, link_pll_auto_reset_en_o}, 3'b001)
        `CHK(event_filter_o, 8'h00)
    endtask
    initial begin
        cyc(16);
        reset_n_i = 1'b1;
        cyc(2);
        t_reset;
        t_early;
        t_ready;
        t_seq_a;
        t_seq_b;
        t_hard;
        end_sim;
    end
    // Watchdog
    initial begin
        #5000000;
        error_cnt++;
        end_sim;
    end
endmodule
